// File: logic/rff_fifo.sv
`timescale 1ns/1ps
`include "rff_regs.svh"
module rff_fifo
    import rff_pkg::*;
(
    // clock and reset
    input  wire logic             CLK_I,
    input  wire logic             RESET_I,
    // register port
    input  wire logic [7:0]       ADDR_I,
    input  wire rff_pkg::rff_word_t WDATA_I,
    input  wire logic             WR_I,
    input  wire logic             RD_I,
    output rff_pkg::rff_word_t    RDATA_O,
    // received frame, one-cycle strobe
    input  wire logic             FRAME_VALID_I,
    input  wire logic [10:0]      FRAME_ID_I,
    input  wire logic [5:0]       FRAME_CYCLE_I,
    input  wire logic             FRAME_ON_B_I,
    input  wire logic             FRAME_STATIC_I,
    input  wire logic             FRAME_NULL_I,
    input  wire logic             FRAME_MATCHED_I,
    input  wire logic             FRAME_OWN_TX_I,
    input  wire logic [15:0]      FRAME_DATA0_I,
    // interrupt
    output logic                  IRQ_O
);
    import rff_pkg::*;

    logic [31:0] part_ff;
    logic [31:0] filt_ff;
    logic [10:0] mask_ff;
    logic [7:0]  thr_ff;
    logic [3:0]  irq_stat_ff;
    logic [3:0]  irq_en_ff;
    logic [7:0]  fill_ff;
    logic [7:0]  wr_idx_ff;
    logic [7:0]  rd_idx_ff;
    logic        ovr_ff;
    logic [31:0] rdata_ff;
    logic [6:0]  wsel_ff;
    logic [15:0] half_mem [0:`RFF_NUM_BUF*`RFF_PAYLOAD_WORDS-1];
    logic [10:0] id_mem [0:`RFF_NUM_BUF-1];
    logic [15:0] xfer_ff [0:`RFF_PAYLOAD_WORDS-1];
    logic [10:0] xfer_id_ff;

    logic [7:0]  ffb;
    logic [7:0]  last_configured_buffer;
    logic [7:0]  depth;
    logic        accept;
    logic        store;
    logic        pop;
    logic        pop_ok;
    logic        wr_hit;
    logic [7:0]  nxt_fill;
    logic        full;

    // next ring index, wrapping from last buffer back to the first fifo buffer
    function automatic logic [7:0] ring_next(input logic [7:0] idx,
                                             input logic [7:0] first,
                                             input logic [7:0] last);
        ring_next = (idx >= last) ? first : 8'(idx + 8'h01);
    endfunction

    assign ffb   = part_ff[`RFF_FFB_LSB +: 8];
    assign last_configured_buffer   = part_ff[`RFF_LCB_LSB +: 8];
    assign depth = 8'(last_configured_buffer - ffb + 8'h01);
    // every configured ring slot holds a frame
    assign full  = (fill_ff == depth);

    rff_filter u_filter
    (
        .fid_i    (FRAME_ID_I),
        .cycle_i  (FRAME_CYCLE_I),
        .on_b_i   (FRAME_ON_B_I),
        .static_i (FRAME_STATIC_I),
        .null_i   (FRAME_NULL_I),
        .filter_i (filt_ff),
        .mask_i   (mask_ff),
        .accept_o (accept)
    );

    // store decision: unmatched, not self-sent, passes the filter
    assign store  = FRAME_VALID_I && !FRAME_MATCHED_I && !FRAME_OWN_TX_I && accept;
    assign wr_hit = WR_I && (ADDR_I == `RFF_OFF_READ_REQ);
    assign pop    = wr_hit;
    assign pop_ok = pop && (fill_ff != 8'h00);

    // fill level: full ring on store overwrites oldest, so level holds
    always_comb
    begin
        nxt_fill = fill_ff;
        if (store && !(fill_ff == depth) && !pop_ok)
            nxt_fill = 8'(fill_ff + 8'h01);
        else if (pop_ok && !store)
            nxt_fill = 8'(fill_ff - 8'h01);
    end

    // configuration registers
    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            part_ff <= {8'h00, 8'h00, 8'h00, `RFF_FDB_DISABLE};
            filt_ff <= 32'h0000_0000;
            mask_ff <= 11'h000;
            thr_ff  <= `RFF_THR_RESET;
            irq_en_ff <= 4'h0;
        end
        else if (WR_I)
        begin
            case (ADDR_I)
                `RFF_OFF_PARTITION:  part_ff   <= WDATA_I;
                `RFF_OFF_FILTER:     filt_ff   <= WDATA_I;
                `RFF_OFF_MASK:       mask_ff   <= WDATA_I[`RFF_FRAME_ID_MASK_LSB +: 11];
                `RFF_OFF_THRESHOLD:  thr_ff    <= WDATA_I[7:0];
                `RFF_OFF_IRQ_ENABLE: irq_en_ff <= WDATA_I[3:0];
                default: ;
            endcase
        end
    end

    // ring pointers and level
    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            fill_ff   <= 8'h00;
            wr_idx_ff <= 8'h00;
            rd_idx_ff <= 8'h00;
            ovr_ff    <= 1'b0;
        end
        else if (WR_I && ADDR_I == `RFF_OFF_PARTITION)
        begin
            // reconfiguration empties the ring
            fill_ff   <= 8'h00;
            wr_idx_ff <= WDATA_I[`RFF_FFB_LSB +: 8];
            rd_idx_ff <= WDATA_I[`RFF_FFB_LSB +: 8];
            ovr_ff    <= 1'b0;
        end
        else
        begin
            fill_ff <= nxt_fill;
            if (store)
                wr_idx_ff <= ring_next(wr_idx_ff, ffb, last_configured_buffer);
            if ((pop_ok) || (store && fill_ff == depth && !pop_ok))
                rd_idx_ff <= ring_next(rd_idx_ff, ffb, last_configured_buffer);
            if (store && fill_ff == depth && !pop_ok)
                ovr_ff <= 1'b1;
            else if (pop)
                ovr_ff <= 1'b0;
        end
    end

    // message storage: id and first halfword at the configured payload slot
    always_ff @(posedge CLK_I)
    begin
        if (store)
        begin
            id_mem[wr_idx_ff[6:0]] <= FRAME_ID_I;
            half_mem[{wr_idx_ff[6:0], 2'b00}] <= FRAME_DATA0_I;
        end
    end

    // transfer to output view: full configured length, unreceived words undefined
    always_ff @(posedge CLK_I)
    begin
        if (pop_ok)
        begin
            xfer_id_ff <= id_mem[rd_idx_ff[6:0]];
            for (int w = 0; w < `RFF_PAYLOAD_WORDS; w++)
                xfer_ff[w] <= half_mem[{rd_idx_ff[6:0], 2'(w)}];
        end
    end

    // sticky interrupt status; set wins over clear
    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
            irq_stat_ff <= 4'h0;
        else
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (WR_I && ADDR_I == `RFF_OFF_IRQ_CLEAR && WDATA_I[b])
                    irq_stat_ff[b] <= 1'b0;
            end
            if (store && fill_ff == 8'h00)
                irq_stat_ff[`RFF_BIT_NE] <= 1'b1;
            if (nxt_fill >= thr_ff && fill_ff < thr_ff)
                irq_stat_ff[`RFF_BIT_CL] <= 1'b1;
            if (store && fill_ff == depth && !pop_ok)
                irq_stat_ff[`RFF_BIT_OVR] <= 1'b1;
            if (pop && fill_ff == 8'h00)
                irq_stat_ff[`RFF_BIT_EFA] <= 1'b1;
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
            rdata_ff <= 32'h0000_0000;
        else if (RD_I)
        begin
            case (ADDR_I)
                `RFF_OFF_PARTITION:  rdata_ff <= part_ff;
                `RFF_OFF_FILTER:     rdata_ff <= filt_ff;
                `RFF_OFF_MASK:       rdata_ff <= {19'h0, mask_ff, 2'b00};
                `RFF_OFF_THRESHOLD:  rdata_ff <= {24'h0, thr_ff};
                `RFF_OFF_STATE:      rdata_ff <= {16'h0, fill_ff, 4'h0, 1'b0, ovr_ff,
                                                 (fill_ff >= thr_ff), (fill_ff != 8'h00)};
                `RFF_OFF_IRQ_STATUS: rdata_ff <= {28'h0, irq_stat_ff};
                `RFF_OFF_IRQ_ENABLE: rdata_ff <= {28'h0, irq_en_ff};
                `RFF_OFF_READ_DATA:  rdata_ff <= {5'h0, xfer_id_ff, xfer_ff[0]};
                default:             rdata_ff <= 32'h0000_0000;
            endcase
        end
        else
            rdata_ff <= 32'h0000_0000;
    end

    assign RDATA_O = rdata_ff;
    assign IRQ_O   = |(irq_stat_ff & irq_en_ff);

    // assertions
    chk_fill_inc: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (store && fill_ff < depth && !pop && !WR_I) |=> fill_ff == $past(fill_ff) + 8'h01)
        else $error("fill level did not step on store");
    chk_fill_hold: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (!store && !WR_I) |=> fill_ff == $past(fill_ff))
        else $error("fill level moved without cause");
    chk_first_store: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (store && fill_ff == 8'h00 && !WR_I) |=> (fill_ff == 8'h01 && irq_stat_ff[0]))
        else $error("first store not flagged");
    chk_own_tx: assert property (@(posedge CLK_I) disable iff (RESET_I)
        FRAME_OWN_TX_I |-> !store)
        else $error("own frame stored");
    chk_null_drop: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (FRAME_NULL_I && filt_ff[`RFF_RNF_BIT]) |-> !store)
        else $error("null frame stored");
    chk_chan_a: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (filt_ff[1:0] == 2'b10 && FRAME_ON_B_I) |-> !store)
        else $error("channel B stored with A-only filter");
    chk_id_mask: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (filt_ff[22:16] == 7'h00 && (((FRAME_ID_I ^ filt_ff[12:2]) & ~mask_ff) == 11'h0))
        |-> !store)
        else $error("rejected id stored");
    chk_empty_acc: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (pop && fill_ff == 8'h00) |=> irq_stat_ff[3])
        else $error("empty access not flagged");

    // an unmatched frame whose masked id misses the filter id and that no other criterion rejects must land in the ring
    chk_pass_store: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (FRAME_VALID_I && !FRAME_MATCHED_I && !FRAME_OWN_TX_I
         && !(FRAME_ON_B_I ? filt_ff[1] : filt_ff[0])
         && !(FRAME_NULL_I && filt_ff[`RFF_RNF_BIT])
         && !(FRAME_STATIC_I && filt_ff[`RFF_RSS_BIT])
         && (((FRAME_ID_I ^ filt_ff[12:2]) & ~mask_ff) != 11'h000)) |-> store)
        else $error("passing frame not stored");

    chk_chan_b: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (filt_ff[1:0] == 2'b01 && !FRAME_ON_B_I) |-> !store)
        else $error("channel A stored with B-only filter");

    // ring bounds and order
    chk_level_cap: assert property (@(posedge CLK_I) disable iff (RESET_I)
        fill_ff <= depth)
        else $error("fill level above ring depth");

    chk_ring_wrap: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (store && !WR_I && wr_idx_ff >= last_configured_buffer) |=> wr_idx_ff == ffb)
        else $error("write index did not wrap to first buffer");

    chk_pop_step: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (pop_ok && rd_idx_ff < last_configured_buffer) |=> rd_idx_ff == $past(rd_idx_ff) + 8'h01)
        else $error("read index did not step on pop");

    chk_fill_pop: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (pop_ok && !store) |=> fill_ff == $past(fill_ff) - 8'h01)
        else $error("fill level did not drop on pop");

    chk_empty_pop: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (pop && fill_ff == 8'h00 && !store) |=> fill_ff == 8'h00)
        else $error("empty pop moved the fill level");

    // overrun overwrites the oldest, so the level stands
    chk_ovr_keep: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (store && full && !WR_I) |=> fill_ff == $past(fill_ff))
        else $error("fill level moved on overrun");

    // level flag and event stay quiet below the threshold
    chk_thr_quiet: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (!irq_stat_ff[`RFF_BIT_CL] && nxt_fill < thr_ff) |=> !irq_stat_ff[`RFF_BIT_CL])
        else $error("threshold event below threshold");

    chk_thr_read: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (RD_I && ADDR_I == `RFF_OFF_STATE && fill_ff < thr_ff) |=> !RDATA_O[`RFF_BIT_CL])
        else $error("threshold state set below threshold");

    chk_ne_read: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (RD_I && ADDR_I == `RFF_OFF_STATE)
        |=> RDATA_O[`RFF_BIT_NE] == ($past(fill_ff) != 8'h00))
        else $error("not-empty state disagrees with level");

    // reset leaves no stale level or flag behind
    chk_reset_clear: assert property (@(posedge CLK_I)
        $fell(RESET_I) |-> (fill_ff == 8'h00 && irq_stat_ff == 4'h0 && !ovr_ff))
        else $error("state not clear after reset");

    cov_store: cover property (@(posedge CLK_I) store);
    cov_pop: cover property (@(posedge CLK_I) pop_ok);
    cov_ovr: cover property (@(posedge CLK_I) store && full);
    cov_empty_pop: cover property (@(posedge CLK_I) pop && fill_ff == 8'h00);
    cov_wrap: cover property (@(posedge CLK_I) store && wr_idx_ff >= last_configured_buffer);
endmodule

// File: logic/rff_filter.sv
`timescale 1ns/1ps
`include "rff_regs.svh"
// combinational rejection filter for one received frame
module rff_filter
    import rff_pkg::*;
(
    // received frame attributes
    input  wire logic [10:0] fid_i,
    input  wire logic [5:0]  cycle_i,
    input  wire logic        on_b_i,
    input  wire logic        static_i,
    input  wire logic        null_i,
    // filter settings
    input  wire logic [31:0] filter_i,
    input  wire logic [10:0] mask_i,
    // decision
    output logic             accept_o
);
    logic [10:0] fid_f;
    logic [6:0]  cycle_filter;
    logic [1:0]  chf;
    logic        id_hit;
    logic        cyc_hit;
    logic        ch_ok;
    logic        found;
    assign fid_f = filter_i[`RFF_FID_LSB +: 11];
    assign cycle_filter   = filter_i[`RFF_CYF_LSB +: 7];
    assign chf   = filter_i[`RFF_CH_LSB +: 2];
    // masked positions are don't care
    assign id_hit = (((fid_i ^ fid_f) & ~mask_i) == 11'h000);
    // zero cycle code applies the id filter every cycle; else match a power-of-two base set
    always_comb
    begin
        cyc_hit = 1'b1;
        found   = 1'b0;
        // highest set bit picks the repetition, the bits below it the base cycle
        for (int k = 6; k >= 0; k--)
        begin
            if (cycle_filter[k] && !found)
            begin
                found   = 1'b1;
                cyc_hit = ((7'({1'b0, cycle_i}) & ((7'h01 << k) - 7'h01))
                           == (cycle_filter & ((7'h01 << k) - 7'h01)));
            end
        end
    end
    // code bit1 blocks channel B, bit0 blocks channel A: 10 passes only A
    assign ch_ok = on_b_i ? ~chf[1] : ~chf[0];
    assign accept_o = ch_ok && !(id_hit && cyc_hit)
                      && !(null_i && filter_i[`RFF_RNF_BIT])
                      && !(static_i && filter_i[`RFF_RSS_BIT]);
endmodule

// File: logic/rff_pkg.sv
package rff_pkg;
    typedef logic [31:0] rff_word_t;
    typedef logic [10:0] rff_fid_t;
    typedef logic [7:0]  rff_idx_t;
    typedef enum logic [1:0] {RFF_CH_NONE, RFF_CH_A, RFF_CH_B} rff_chan_t;
endpackage

// File: logic/rff_regs.svh
`ifndef RFF_REGS_SVH
`define RFF_REGS_SVH
// register offsets (byte addresses)
`define RFF_OFF_PARTITION   8'h00
`define RFF_OFF_FILTER      8'h04
`define RFF_OFF_MASK        8'h08
`define RFF_OFF_THRESHOLD   8'h0C
`define RFF_OFF_STATE       8'h10
`define RFF_OFF_IRQ_STATUS  8'h14
`define RFF_OFF_IRQ_CLEAR   8'h18
`define RFF_OFF_IRQ_ENABLE  8'h1C
`define RFF_OFF_READ_REQ    8'h20
`define RFF_OFF_READ_DATA   8'h24
// partition config fields
`define RFF_LCB_LSB         16
`define RFF_FDB_LSB         0
`define RFF_FFB_LSB         8
`define RFF_FDB_DISABLE     8'h80
// threshold reset keeps the level flag quiet until the host programs it
`define RFF_THR_RESET       8'hFF
// filter fields; channel code sits below the frame id
`define RFF_FID_LSB         2
`define RFF_CYF_LSB         16
`define RFF_CH_LSB          0
// mask field lines up with the filter frame id
`define RFF_FRAME_ID_MASK_LSB        2
`define RFF_RSS_BIT         23
`define RFF_RNF_BIT         24
// interrupt / state bit positions
`define RFF_BIT_NE          0
`define RFF_BIT_CL          1
`define RFF_BIT_OVR         2
`define RFF_BIT_EFA         3
`define RFF_FILL_LSB        8
// sizing
`define RFF_NUM_BUF         128
`define RFF_HDR_WORDS       4
`define RFF_PAYLOAD_WORDS   4
`endif

// File: tb/rff_fifo_bench.sv
`timescale 1ns/1ps
`include "rff_regs.svh"
module rff_fifo_bench;
    import rff_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    rff_word_t wdata = 32'h0000_0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    rff_word_t rdata;
    logic irq;
    logic f_valid, f_on_b, f_static, f_null, f_matched, f_own;
    logic [10:0] f_id;
    logic [5:0] f_cyc;
    logic [15:0] f_data;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h0000_0043;
    logic [26:0] q[$];
    logic [31:0] flt[6] = '{32'h0100_0026, 32'h0000_0002, 32'h0080_0004,
                            32'h0100_0001, 32'h0000_0006, 32'h0006_0000};
    logic [10:0] msk[6] = '{11'h00A, 11'h000, 11'h7F0, 11'h7F0, 11'h000, 11'h7FF};

    // clock, 100 MHz
    always #5 clk = ~clk;

    rff_fifo u_rff_fifo (.CLK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr_en), .RD_I(rd_en), .RDATA_O(rdata), .FRAME_VALID_I(f_valid),
        .FRAME_ID_I(f_id), .FRAME_CYCLE_I(f_cyc), .FRAME_ON_B_I(f_on_b),
        .FRAME_STATIC_I(f_static), .FRAME_NULL_I(f_null), .FRAME_MATCHED_I(f_matched),
        .FRAME_OWN_TX_I(f_own), .FRAME_DATA0_I(f_data), .IRQ_O(irq));

    rff_node_model u_rff_node_model (.clk_i(clk), .valid_o(f_valid), .fid_o(f_id),
        .cyc_o(f_cyc), .on_b_o(f_on_b), .static_o(f_static), .null_o(f_null),
        .matched_o(f_matched), .own_o(f_own), .data_o(f_data));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // expected filter verdict; at is on_b, static, null, matched, own; c is the cycle
    function automatic logic keep(input logic [31:0] f, input logic [10:0] m,
                                  input logic [10:0] id, input logic [4:0] at,
                                  input logic [5:0] c);
        logic rej;
        logic cyc;
        // top set cycle filter bit is the repetition, the bits below it the base
        cyc = (f[22:16] == 7'h00);
        for (int k = 0; k < 7; k++)
            if (f[16 + k])
                cyc = ((c ^ f[21:16]) & 6'((7'h01 << k) - 7'h01)) == 6'h00;
        rej = cyc && (((id ^ f[12:2]) & ~m) == 11'h000);
        rej = rej | (at[4] ? f[1] : f[0]);
        rej = rej | (at[3] & f[23]) | (at[2] & f[24]);
        return !(rej | at[1] | at[0]);
    endfunction

    function automatic logic [31:0] st_exp(input logic [7:0] n, input logic [7:0] t);
        return {16'h0000, n, 5'h00, 1'b0, n >= t, n != 8'h00};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            conclude();
        end
    end

    initial
    begin
        logic [31:0] d, r;
        logic [7:0] thr;
        logic [4:0] at;
        logic [10:0] id;
        logic [5:0] cyc;
        logic any;
        logic hi;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(`RFF_OFF_STATE, d);
        check("state", d, 32'h0000_0000);
        rd(`RFF_OFF_IRQ_STATUS, d);
        check("irq status", d, 32'h0000_0000);
        rd(`RFF_OFF_THRESHOLD, d);
        check("threshold", d, 32'h0000_00FF);
        rd(`RFF_OFF_PARTITION, d);
        check("partition", d, 32'h0000_0080);
        rd(8'h40, d);
        check("unmapped", d, 32'h0000_0000);
        // eight ring buffers, first fifo 1, dynamic buffers off
        wr(`RFF_OFF_PARTITION, 32'h0008_0180);
        rd(`RFF_OFF_PARTITION, d);
        check("partition", d, 32'h0008_0180);
        for (int p = 0; p < 6; p++)
        begin
            any = 1'b0;
            hi = 1'b0;
            wr(`RFF_OFF_FILTER, flt[p]);
            wr(`RFF_OFF_MASK, {19'h0_0000, msk[p], 2'b00});
            thr = 8'(rnd() % 5 + 1);
            wr(`RFF_OFF_THRESHOLD, {24'h00_0000, thr});
            wr(`RFF_OFF_IRQ_CLEAR, 32'h0000_000F);
            wr(`RFF_OFF_IRQ_ENABLE, {31'h0000_0000, p[0]});
            for (int k = 0; k < 7; k++)
            begin
                r = rnd();
                at = {r[4], r[5], r[6] & r[7], r[8] & r[9] & r[10], r[11] & r[12] & r[13]};
                id = {7'h00, r[3:0]};
                // the model steps its cycle number by five per frame
                cyc = 6'(f_cyc + 6'h05);
                u_rff_node_model.send(id, at, r[31:16]);
                if (keep(flt[p], msk[p], id, at, cyc))
                begin
                    q.push_back({id, r[31:16]});
                    any = 1'b1;
                end
                hi = hi | (8'(q.size()) >= thr);
                rd(`RFF_OFF_STATE, d);
                check("state", d, st_exp(8'(q.size()), thr));
            end
            rd(`RFF_OFF_IRQ_STATUS, d);
            check("not empty event", {31'h0, d[0]}, {31'h0, any});
            check("threshold event", {31'h0, d[1]}, {31'h0, hi});
            check("irq", {31'h0, irq}, {31'h0, any & p[0]});
            wr(`RFF_OFF_IRQ_CLEAR, 32'h0000_000F);
            rd(`RFF_OFF_IRQ_STATUS, d);
            check("cleared", {29'h0, irq, d[1:0]}, 32'h0000_0000);
            while (q.size() > 0)
            begin
                wr(`RFF_OFF_READ_REQ, 32'h0000_0000);
                rd(`RFF_OFF_READ_DATA, d);
                check("oldest frame", d, {5'h00, q.pop_front()});
            end
            rd(`RFF_OFF_STATE, d);
            check("drained", d, st_exp(8'h00, thr));
        end
        // pop from an empty ring only flags the access
        wr(`RFF_OFF_READ_REQ, 32'h0000_0000);
        rd(`RFF_OFF_IRQ_STATUS, d);
        check("empty access", d, 32'h0000_0008);
        rd(`RFF_OFF_STATE, d);
        check("state", d, 32'h0000_0000);
        conclude();
    end
endmodule

// File: tb/rff_node_model.sv
`timescale 1ns/1ps
// bus node model: hands one received frame to the fifo per call
module rff_node_model
(
    // clock
    input  wire logic        clk_i,
    // received frame
    output logic             valid_o,
    output logic [10:0]      fid_o,
    output logic [5:0]       cyc_o,
    output logic             on_b_o,
    output logic             static_o,
    output logic             null_o,
    output logic             matched_o,
    output logic             own_o,
    output logic [15:0]      data_o
);
    initial
    begin
        valid_o = 1'b0;
        fid_o = 11'h000;
        cyc_o = 6'h00;
        {on_b_o, static_o, null_o, matched_o, own_o} = 5'h00;
        data_o = 16'h0000;
    end

    // attribute order: on_b, static, null, matched, own
    task automatic send(input logic [10:0] id, input logic [4:0] at, input logic [15:0] d);
        @(posedge clk_i);
        valid_o <= 1'b1;
        fid_o <= id;
        {on_b_o, static_o, null_o, matched_o, own_o} <= at;
        data_o <= d;
        cyc_o <= cyc_o + 6'h05; // cycle number moves on
        @(posedge clk_i);
        valid_o <= 1'b0;
        // id, attribute and data lines outside a frame carry junk, never the last value
        fid_o <= ~id;
        {on_b_o, static_o, null_o, matched_o, own_o} <= ~at;
        data_o <= ~d;
    endtask
endmodule
